// file: src/ifs_pkg.sv
// Field layout, encodings and opcodes of the integer and FP status flags
package ifs_pkg;
  // ---------------------------------------------------------------
  // Integer exception register layout (vector bit = 31 - doc bit)
  // ---------------------------------------------------------------
  localparam int XER_SO = 31;
  localparam int XER_OV = 30;
  localparam int XER_CA = 29;
  localparam int XER_RSV_HI = 28;
  localparam int XER_RSV_LO = 7;
  localparam int XER_CNT_HI = 6;
  localparam int XER_CNT_LO = 0;
  localparam logic [31:0] XER_RESET = 32'h0;
  localparam logic [6:0] CNT_RESET = 7'h0;

  // ---------------------------------------------------------------
  // FP status/control tail layout
  // ---------------------------------------------------------------
  localparam int FP_RELAX = 2;
  localparam int FP_RND_HI = 1;
  localparam int FP_RND_LO = 0;
  localparam int FP_CLS_HI = 16;
  localparam int FP_CLS_LO = 12;
  localparam logic [31:0] FP_RESET = 32'h0;

  // Rounding select codes and the one-hot decode base
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_PINF = 2'h2;
  localparam logic [1:0] RND_NINF = 2'h3;
  localparam logic [3:0] RND_ONEHOT_BASE = 4'h1;

  // Result-class flag codes
  localparam logic [4:0] CLS_QNAN = 5'h11;
  localparam logic [4:0] CLS_NINF = 5'h09;
  localparam logic [4:0] CLS_NNORM = 5'h08;
  localparam logic [4:0] CLS_NDEN = 5'h18;
  localparam logic [4:0] CLS_NZERO = 5'h12;
  localparam logic [4:0] CLS_PZERO = 5'h02;
  localparam logic [4:0] CLS_PDEN = 5'h14;
  localparam logic [4:0] CLS_PNORM = 5'h04;
  localparam logic [4:0] CLS_PINF = 5'h05;

  // Word constants for overflow tests
  localparam logic [31:0] WORD_MIN = 32'h8000_0000;
  localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_ZERO = 32'h0;

  typedef enum logic [3:0] {
    OP_ADD, OP_SUBF, OP_NEG, OP_ADDC, OP_SUBFC, OP_ADDE, OP_SUBFE,
    OP_MULLW, OP_DIVW, OP_DIVWU, OP_SRAW, OP_CMP, OP_OTHER
  } ifs_op_type;

  typedef enum logic [3:0] {
    C_QNAN, C_NINF, C_NNORM, C_NDEN, C_NZERO, C_PZERO, C_PDEN, C_PNORM, C_PINF
  } ifs_class_type;
endpackage

// file: src/ifs_status_flags.sv
// Integer exception register and FP status/control tail flag logic
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] Relaxed mode flushes denormal results to signed zero, only while fpImplOk is high
// [RL2] Two-bit field selects one of four roundings
// [RL3] Result class encoded into five flag bits
// [RL4] Integer exception register is full 32-bit word
// [RL5] Flags come from whole result, not partials
// [RL6] Sticky bit sets with wrap, clears by write/copy
// [RL7] Non-overflowing instructions keep sticky bit
// [RL8] Write of sticky zero, wrap one obeyed
// [RL9] Add family wrap from msb carry mismatch
// [RL10] Multiply/divide wrap when result exceeds word
// [RL11] Non-overflowing instructions keep signed wrap flag
// [RL12] Carrying/extended adds set carry on msb carry-out
// [RL13] Algebraic right shift carry on lost ones of a negative source
// [RL14] Non-carrying instructions keep unsigned wrap bit
// [RL15] Low seven bits hold string byte count
// [RL16] Reserved bits read zero, writes ignored
module ifs_status_flags (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Integer completion
  input wire logic intDone,
  input wire ifs_pkg::ifs_op_type intOp,
  input wire logic intOvEnable,
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire logic [5:0] shiftAmt,
  // Special-register access
  input wire logic spWrite,
  input wire logic [31:0] spData,
  input wire logic crCopyReq,
  input wire logic fpCtlWrite,
  input wire logic [31:0] fpCtlData,
  // FP completion
  input wire logic fpDone,
  input wire ifs_pkg::ifs_class_type fpClass,
  input wire logic fpImplOk,
  // Outputs
  output logic [31:0] xerValue,
  output logic [3:0] crCopy,
  output logic [6:0] byteCount,
  output logic [31:0] fpStatus,
  output logic [3:0] roundMode,
  output logic flushZero
);
  // ---------------------------------------------------------------
  // Integer flag computation
  // ---------------------------------------------------------------
  logic [31:0] x;
  logic [31:0] y;
  logic cin;
  logic [32:0] sum;
  logic signed [63:0] prod;
  logic ovUpd;
  logic ovCalc;
  logic caUpd;
  logic caCalc;
  logic addOv;

  assign prod = $signed(opA) * $signed(opB);
  // Three-operand sum taken as a whole, so carry-in is never split off
  assign sum = {1'h0, x} + {1'h0, y} + {32'h0, cin}; // RL5
  // Carry out of msb versus carry into it
  assign addOv = sum[32] ^ (x[31] ^ y[31] ^ sum[31]); // RL9

  always_comb
  begin
    x = opA;
    y = opB;
    cin = 1'h0;
    ovUpd = 1'h0;
    ovCalc = 1'h0;
    caUpd = 1'h0;
    caCalc = 1'h0;
    unique case (intOp)
      ifs_pkg::OP_ADD, ifs_pkg::OP_ADDC, ifs_pkg::OP_ADDE:
      begin
        if (intOp == ifs_pkg::OP_ADDE)
          cin = xerValue[ifs_pkg::XER_CA];
        ovUpd = intOvEnable; // RL9
        ovCalc = addOv;
        caUpd = (intOp != ifs_pkg::OP_ADD); // RL12
        caCalc = sum[32];
      end
      ifs_pkg::OP_SUBF, ifs_pkg::OP_SUBFC, ifs_pkg::OP_SUBFE:
      begin
        x = ~opA;
        cin = (intOp == ifs_pkg::OP_SUBFE) ? xerValue[ifs_pkg::XER_CA] : 1'h1;
        ovUpd = intOvEnable; // RL9
        ovCalc = addOv;
        caUpd = (intOp != ifs_pkg::OP_SUBF); // RL12
        caCalc = sum[32];
      end
      ifs_pkg::OP_NEG:
      begin
        x = ~opA;
        y = ifs_pkg::WORD_ZERO;
        cin = 1'h1;
        ovUpd = intOvEnable; // RL9
        ovCalc = addOv;
      end
      ifs_pkg::OP_MULLW:
      begin
        ovUpd = intOvEnable; // RL10
        ovCalc = (prod[63:31] != {33{prod[31]}});
      end
      ifs_pkg::OP_DIVW:
      begin
        ovUpd = intOvEnable; // RL10
        ovCalc = (opB == ifs_pkg::WORD_ZERO) ||
                 (opA == ifs_pkg::WORD_MIN && opB == ifs_pkg::WORD_ONES);
      end
      ifs_pkg::OP_DIVWU:
      begin
        ovUpd = intOvEnable; // RL10
        ovCalc = (opB == ifs_pkg::WORD_ZERO);
      end
      ifs_pkg::OP_SRAW:
      begin
        caUpd = 1'h1; // RL13
        // Shift of 32 or more drops every bit, so sign alone decides
        if (shiftAmt[5])
          caCalc = opA[31];
        else
          caCalc = opA[31] && |(opA & ~(ifs_pkg::WORD_ONES << shiftAmt[4:0]));
      end
      // Compares and the rest cannot wrap or carry
      ifs_pkg::OP_CMP, ifs_pkg::OP_OTHER:
      begin
        ovUpd = 1'h0; // RL7 RL11 RL14
      end
      default:
      begin
        ovUpd = 1'h0;
      end
    endcase
  end

  logic intOv;
  logic intCa;
  assign intOv = intDone && ovUpd;
  assign intCa = intDone && caUpd;

  // ---------------------------------------------------------------
  // Integer exception register
  // ---------------------------------------------------------------
  logic next_so;
  logic next_ov;
  logic next_ca;

  always_comb
  begin
    next_so = xerValue[ifs_pkg::XER_SO];
    next_ov = xerValue[ifs_pkg::XER_OV];
    next_ca = xerValue[ifs_pkg::XER_CA];
    if (spWrite)
    begin
      // Sticky taken as written, never derived from the written wrap flag
      next_so = spData[ifs_pkg::XER_SO]; // RL8
      next_ov = spData[ifs_pkg::XER_OV];
      next_ca = spData[ifs_pkg::XER_CA];
    end
    else if (crCopyReq)
    begin
      next_so = 1'h0; // RL6
      next_ov = 1'h0;
      next_ca = 1'h0;
    end
    // Hardware updates win over a same-cycle clear
    if (intOv)
      next_ov = ovCalc; // RL9 RL10 RL11
    if (intOv && ovCalc)
      next_so = 1'h1; // RL6 RL7
    if (intCa)
      next_ca = caCalc; // RL12 RL13 RL14
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      xerValue <= ifs_pkg::XER_RESET;
    else if (ce)
    begin
      xerValue[ifs_pkg::XER_SO] <= next_so;
      xerValue[ifs_pkg::XER_OV] <= next_ov;
      xerValue[ifs_pkg::XER_CA] <= next_ca;
      xerValue[ifs_pkg::XER_RSV_HI:ifs_pkg::XER_RSV_LO] <= '0; // RL4 RL16
      if (spWrite)
        xerValue[ifs_pkg::XER_CNT_HI:ifs_pkg::XER_CNT_LO] <=
          spData[ifs_pkg::XER_CNT_HI:ifs_pkg::XER_CNT_LO]; // RL15
    end
  end

  // Byte count mirror for the string unit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      byteCount <= ifs_pkg::CNT_RESET;
    else if (ce && spWrite)
      byteCount <= spData[ifs_pkg::XER_CNT_HI:ifs_pkg::XER_CNT_LO]; // RL15
  end

  // Copy of the top four bits taken before the clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      crCopy <= 4'h0;
    else if (ce && crCopyReq)
      crCopy <= xerValue[ifs_pkg::XER_SO -: 4]; // RL6
  end

  // ---------------------------------------------------------------
  // FP status/control tail
  // ---------------------------------------------------------------
  logic flushNow;
  logic [4:0] clsCode;

  assign flushNow = fpDone && fpImplOk && fpStatus[ifs_pkg::FP_RELAX] &&
                    (fpClass == ifs_pkg::C_NDEN || fpClass == ifs_pkg::C_PDEN);

  always_comb
  begin
    clsCode = ifs_pkg::CLS_PZERO;
    unique case (fpClass)
      ifs_pkg::C_QNAN: clsCode = ifs_pkg::CLS_QNAN; // RL3
      ifs_pkg::C_NINF: clsCode = ifs_pkg::CLS_NINF;
      ifs_pkg::C_NNORM: clsCode = ifs_pkg::CLS_NNORM;
      ifs_pkg::C_NDEN: clsCode = flushNow ? ifs_pkg::CLS_NZERO : ifs_pkg::CLS_NDEN; // RL1
      ifs_pkg::C_NZERO: clsCode = ifs_pkg::CLS_NZERO;
      ifs_pkg::C_PZERO: clsCode = ifs_pkg::CLS_PZERO;
      ifs_pkg::C_PDEN: clsCode = flushNow ? ifs_pkg::CLS_PZERO : ifs_pkg::CLS_PDEN; // RL1
      ifs_pkg::C_PNORM: clsCode = ifs_pkg::CLS_PNORM;
      ifs_pkg::C_PINF: clsCode = ifs_pkg::CLS_PINF;
      default: clsCode = ifs_pkg::CLS_QNAN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      fpStatus <= ifs_pkg::FP_RESET;
    else if (ce)
    begin
      if (fpCtlWrite)
      begin
        fpStatus[ifs_pkg::FP_RELAX] <= fpCtlData[ifs_pkg::FP_RELAX];
        fpStatus[ifs_pkg::FP_RND_HI:ifs_pkg::FP_RND_LO] <=
          fpCtlData[ifs_pkg::FP_RND_HI:ifs_pkg::FP_RND_LO];
      end
      // A completing result overrides a same-cycle software write
      if (fpDone)
        fpStatus[ifs_pkg::FP_CLS_HI:ifs_pkg::FP_CLS_LO] <= clsCode; // RL3
      else if (fpCtlWrite)
        fpStatus[ifs_pkg::FP_CLS_HI:ifs_pkg::FP_CLS_LO] <=
          fpCtlData[ifs_pkg::FP_CLS_HI:ifs_pkg::FP_CLS_LO];
    end
  end

  // One-hot rounding selection for the FP datapath
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      roundMode <= ifs_pkg::RND_ONEHOT_BASE;
    else if (ce && fpCtlWrite)
      roundMode <= ifs_pkg::RND_ONEHOT_BASE <<
        fpCtlData[ifs_pkg::FP_RND_HI:ifs_pkg::FP_RND_LO]; // RL2
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flushZero <= 1'h0;
    else if (ce)
      flushZero <= flushNow; // RL1
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic refAddOv;
  logic [32:0] refCarry;
  assign refCarry = {1'h0, opA} + {1'h0, opB};
  assign refAddOv = (opA[31] == opB[31]) && (refCarry[31] != opA[31]);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_rndWrite;
    ce && fpCtlWrite;
  endsequence
  sequence s_denFlush;
    ce && fpDone && fpImplOk && fpStatus[ifs_pkg::FP_RELAX] && fpClass == ifs_pkg::C_NDEN;
  endsequence

  property p_soSet;
    ce && intDone && intOvEnable && intOp == ifs_pkg::OP_ADD && refAddOv |=>
      xerValue[ifs_pkg::XER_SO] && xerValue[ifs_pkg::XER_OV];
  endproperty
  a_soSet: assert property (p_soSet) else $error("sticky or wrap not set"); // RL6
  property p_soHold;
    ce && !spWrite && !crCopyReq && intDone && intOp == ifs_pkg::OP_CMP |=>
      $stable(xerValue[31:29]);
  endproperty
  a_soHold: assert property (p_soHold) else $error("compare altered flags"); // RL7
  property p_mtWrite;
    ce && spWrite && !intDone && !spData[ifs_pkg::XER_SO] && spData[ifs_pkg::XER_OV] |=>
      !xerValue[ifs_pkg::XER_SO] && xerValue[ifs_pkg::XER_OV];
  endproperty
  a_mtWrite: assert property (p_mtWrite) else $error("write of flags mishandled"); // RL8
  property p_addOv;
    ce && intDone && intOvEnable && intOp == ifs_pkg::OP_ADD |=>
      xerValue[ifs_pkg::XER_OV] == $past(refAddOv);
  endproperty
  a_addOv: assert property (p_addOv) else $error("add wrap flag wrong"); // RL9
  property p_addCa;
    ce && intDone && intOp == ifs_pkg::OP_ADDC |=>
      xerValue[ifs_pkg::XER_CA] == $past(refCarry[32]);
  endproperty
  a_addCa: assert property (p_addCa) else $error("carry flag wrong"); // RL12
  property p_sraPos;
    ce && intDone && intOp == ifs_pkg::OP_SRAW && !opA[31] |=> !xerValue[ifs_pkg::XER_CA];
  endproperty
  a_sraPos: assert property (p_sraPos) else $error("shift carry on positive"); // RL13
  property p_copyClr;
    ce && crCopyReq && !spWrite && !intDone |=>
      crCopy == $past(xerValue[31:28]) && xerValue[31:29] == 3'h0;
  endproperty
  a_copyClr: assert property (p_copyClr) else $error("copy-clear wrong"); // RL6
  property p_rsvZero;
    xerValue[ifs_pkg::XER_RSV_HI:ifs_pkg::XER_RSV_LO] == '0 && fpStatus[31:17] == '0;
  endproperty
  a_rsvZero: assert property (p_rsvZero) else $error("reserved bits set"); // RL16
  property p_round;
    s_rndWrite |=> roundMode == (ifs_pkg::RND_ONEHOT_BASE <<
      $past(fpCtlData[ifs_pkg::FP_RND_HI:ifs_pkg::FP_RND_LO]));
  endproperty
  a_round: assert property (p_round) else $error("rounding decode wrong"); // RL2
  property p_flush;
    s_denFlush |=> flushZero &&
      fpStatus[ifs_pkg::FP_CLS_HI:ifs_pkg::FP_CLS_LO] == ifs_pkg::CLS_NZERO;
  endproperty
  a_flush: assert property (p_flush) else $error("denormal not flushed"); // RL1
  property p_clsInf;
    ce && fpDone && fpClass == ifs_pkg::C_PINF |=>
      fpStatus[ifs_pkg::FP_CLS_HI:ifs_pkg::FP_CLS_LO] == ifs_pkg::CLS_PINF;
  endproperty
  a_clsInf: assert property (p_clsInf) else $error("class code wrong"); // RL3
endmodule

`default_nettype wire

// file: verification/ifs_status_flags_tb.sv
// Self-checking testbench for the integer and FP status flag block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic intDone = 1'b0;
  ifs_pkg::ifs_op_type intOp = ifs_pkg::OP_OTHER;
  logic intOvEnable = 1'b0;
  logic [31:0] opA = 32'h0;
  logic [31:0] opB = 32'h0;
  logic [5:0] shiftAmt = 6'h0;
  logic spWrite = 1'b0;
  logic [31:0] spData = 32'h0;
  logic crCopyReq = 1'b0;
  logic fpCtlWrite = 1'b0;
  logic [31:0] fpCtlData = 32'h0;
  logic fpDone = 1'b0;
  ifs_pkg::ifs_class_type fpClass = ifs_pkg::C_PZERO;
  logic fpImplOk = 1'b0;
  logic [31:0] xerValue;
  logic [3:0] crCopy;
  logic [6:0] byteCount;
  logic [31:0] fpStatus;
  logic [3:0] roundMode;
  logic flushZero;
  int nFail = 0;
  int nChecks = 0;
  int cycles = 0;

  ifs_status_flags u_ifs_status_flags (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .intDone(intDone), .intOp(intOp),
    .intOvEnable(intOvEnable), .opA(opA), .opB(opB), .shiftAmt(shiftAmt),
    .spWrite(spWrite), .spData(spData), .crCopyReq(crCopyReq),
    .fpCtlWrite(fpCtlWrite), .fpCtlData(fpCtlData), .fpDone(fpDone),
    .fpClass(fpClass), .fpImplOk(fpImplOk), .xerValue(xerValue), .crCopy(crCopy),
    .byteCount(byteCount), .fpStatus(fpStatus), .roundMode(roundMode),
    .flushZero(flushZero)
  );

  always #5 mclk = ~mclk;

  // Cuts a hang short; the whole run needs well under this
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      nFail++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Operand B mirrors A for shifts, though the shift carry logic reads only opA
  task automatic int_op(input ifs_pkg::ifs_op_type op, input logic oe, input logic [31:0] a,
                        input logic [31:0] b, input logic [5:0] sh, input logic [31:0] exp);
    intOp = op;
    intOvEnable = oe;
    opA = a;
    opB = b;
    shiftAmt = sh;
    intDone = 1'b1;
    step();
    intDone = 1'b0;
    `CHK("xerValue", exp, xerValue)
  endtask

  task automatic sp_write(input logic [31:0] d, input logic [31:0] exp);
    spData = d;
    spWrite = 1'b1;
    step();
    spWrite = 1'b0;
    `CHK("xerValue", exp, xerValue)
  endtask

  task automatic fp_ctl(input logic [31:0] d);
    fpCtlData = d;
    fpCtlWrite = 1'b1;
    step();
    fpCtlWrite = 1'b0;
  endtask

  task automatic fp_result(input ifs_pkg::ifs_class_type c, input logic impl,
                           input logic [4:0] expCls, input logic expFlush);
    fpClass = c;
    fpImplOk = impl;
    fpDone = 1'b1;
    step();
    fpDone = 1'b0;
    `CHK("classFlags", expCls, fpStatus[16:12])
    `CHK("flushZero", expFlush, flushZero)
    step();
    `CHK("flushZeroEnd", 1'b0, flushZero)
  endtask

  task automatic test_reset();
    `CHK("xerReset", 32'h0, xerValue)
    `CHK("fpReset", 32'h0, fpStatus)
    `CHK("roundReset", 4'h1, roundMode)
    `CHK("crCopyReset", 4'h0, crCopy)
  endtask

  task automatic test_wrap_sticky();
    int_op(ifs_pkg::OP_ADD, 1'b1, 32'h7FFF_FFFF, 32'h1, 6'h0, 32'hC000_0000);
    int_op(ifs_pkg::OP_ADD, 1'b1, 32'h1, 32'h1, 6'h0, 32'h8000_0000);
    int_op(ifs_pkg::OP_CMP, 1'b1, 32'hFFFF_FFFF, 32'h1, 6'h0, 32'h8000_0000);
    crCopyReq = 1'b1;
    step();
    crCopyReq = 1'b0;
    `CHK("crCopy", 4'h8, crCopy)
    `CHK("xerValue", 32'h0, xerValue)
    sp_write(32'h4000_0005, 32'h4000_0005);
    `CHK("byteCount", 7'h05, byteCount)
    sp_write(32'hFFFF_FFFF, 32'hE000_007F);
    `CHK("byteCount", 7'h7F, byteCount)
    ce = 1'b0;
    sp_write(32'h0, 32'hE000_007F);
    ce = 1'b1;
    sp_write(32'h0, 32'h0);
  endtask

  task automatic test_carry();
    int_op(ifs_pkg::OP_ADDC, 1'b0, 32'hFFFF_FFFF, 32'h1, 6'h0, 32'h2000_0000);
    int_op(ifs_pkg::OP_ADD, 1'b0, 32'h7FFF_FFFF, 32'h1, 6'h0, 32'h2000_0000);
    int_op(ifs_pkg::OP_CMP, 1'b0, 32'h0, 32'h1, 6'h0, 32'h2000_0000);
    int_op(ifs_pkg::OP_SUBFE, 1'b0, 32'h0, 32'h0, 6'h0, 32'h2000_0000);
    sp_write(32'h0, 32'h0);
    int_op(ifs_pkg::OP_SUBFE, 1'b0, 32'h0, 32'h0, 6'h0, 32'h0);
    int_op(ifs_pkg::OP_SUBFC, 1'b0, 32'h0, 32'h0, 6'h0, 32'h2000_0000);
    int_op(ifs_pkg::OP_ADDE, 1'b0, 32'h0, 32'h0, 6'h0, 32'h0);
    int_op(ifs_pkg::OP_SRAW, 1'b0, 32'h8000_0001, 32'h8000_0001, 6'h01, 32'h2000_0000);
    int_op(ifs_pkg::OP_SRAW, 1'b0, 32'h8000_0000, 32'h8000_0000, 6'h01, 32'h0);
    int_op(ifs_pkg::OP_SRAW, 1'b0, 32'h0000_0001, 32'h0000_0001, 6'h01, 32'h0);
  endtask

  task automatic test_muldiv();
    int_op(ifs_pkg::OP_MULLW, 1'b1, 32'h0001_0000, 32'h0001_0000, 6'h0, 32'hC000_0000);
    int_op(ifs_pkg::OP_MULLW, 1'b1, 32'h2, 32'h3, 6'h0, 32'h8000_0000);
    sp_write(32'h0, 32'h0);
    int_op(ifs_pkg::OP_DIVWU, 1'b1, 32'h0, 32'h0, 6'h0, 32'hC000_0000);
    sp_write(32'h0, 32'h0);
    int_op(ifs_pkg::OP_DIVW, 1'b1, 32'h0, 32'h0, 6'h0, 32'hC000_0000);
    int_op(ifs_pkg::OP_DIVW, 1'b1, 32'h6, 32'h6, 6'h0, 32'h8000_0000);
    sp_write(32'h0, 32'h0);
  endtask

  // Negate, plain subtract-from, copy racing a wrap, and a frozen completion
  task automatic test_neg_subf();
    int_op(ifs_pkg::OP_NEG, 1'b1, 32'h8000_0000, 32'h0, 6'h0, 32'hC000_0000);
    int_op(ifs_pkg::OP_SUBF, 1'b1, 32'h1, 32'h3, 6'h0, 32'h8000_0000);
    crCopyReq = 1'b1;
    int_op(ifs_pkg::OP_ADD, 1'b1, 32'h7FFF_FFFF, 32'h1, 6'h0, 32'hC000_0000);
    crCopyReq = 1'b0;
    `CHK("crCopyRace", 4'h8, crCopy)
    ce = 1'b0;
    int_op(ifs_pkg::OP_ADD, 1'b1, 32'h1, 32'h1, 6'h0, 32'hC000_0000);
    ce = 1'b1;
    sp_write(32'h0, 32'h0);
  endtask

  task automatic test_fp();
    logic [4:0] codes [9];
    codes = '{ifs_pkg::CLS_QNAN, ifs_pkg::CLS_NINF, ifs_pkg::CLS_NNORM, ifs_pkg::CLS_NDEN,
              ifs_pkg::CLS_NZERO, ifs_pkg::CLS_PZERO, ifs_pkg::CLS_PDEN, ifs_pkg::CLS_PNORM,
              ifs_pkg::CLS_PINF};
    for (int i = 0; i < 4; i++)
    begin
      fp_ctl(32'(i));
      `CHK("roundMode", 4'h1 << i, roundMode)
      `CHK("roundField", 2'(i), fpStatus[1:0])
    end
    fp_ctl(32'h0);
    for (int i = 0; i < 9; i++)
      fp_result(ifs_pkg::ifs_class_type'(i), 1'b1, codes[i], 1'b0);
    fp_ctl(32'h4);
    `CHK("relaxedBit", 1'b1, fpStatus[2])
    fp_result(ifs_pkg::C_NDEN, 1'b1, 5'h12, 1'b1);
    fp_result(ifs_pkg::C_PDEN, 1'b1, 5'h02, 1'b1);
    fp_result(ifs_pkg::C_PDEN, 1'b0, 5'h14, 1'b0);
    fp_result(ifs_pkg::C_PNORM, 1'b1, 5'h04, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_wrap_sticky();
    test_carry();
    test_muldiv();
    test_neg_subf();
    test_fp();
    tally_and_finish();
  end
endmodule

`default_nettype wire
